/* File: rtl/rcd_decoder.sv */
// Serial command decoder: shifts 16-bit words from the host and updates
// the receiver configuration registers.
// Assumes SCK, SELECT_N and SERIAL_IN come from a host outside the CLK
// domain, with SCK periods well above four CLK periods.
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// - Sample serial_in MSB first on each rising serial clock while select low.
// - Select high clears the shifter; commands come in whole 16-bit words.
// - Every command register loads its default word at reset.
// - Config word holds band, crystal load and bandwidth codes.
// - Battery detector and wake timer run only while enabled.
// - Crystal keep bit holds oscillator on during sleep.
// - Clock disable bit stops the microcontroller clock output.
// - Frequency command carries 12-bit word in bits 11 to 0.
// - Frequency words outside 96..3903 are ignored, old value kept.
// - Synth frequency is 10 MHz * C1 * (C2 + F/4000) per band.
// - Receiver bits 7-6 route the valid data indicator source.
// - Receiver bits 5-4 set LNA gain 0, -14, -6, -20 dB.
// - Receiver bits 3-1 set strength threshold -103 to -61 dBm.
// - Effective threshold equals programmed threshold plus LNA gain.
// - Receiver bit 0 enables receive chain and crystal, and with them the clock output.
// - Crystal off via receiver enable stops clock output at once.
// - Wake period is M times 2^R ms from bits 7-0 and 12-8.
// - Duty-cycle mode uses the wake period as its cycle.
// - Duty bit 0 enables; on fraction (2D+1)/M.
// - Battery threshold is 2.2 V plus T times 0.1 V.
// - Battery word bits 7-5 select microcontroller clock frequency.
// - Interrupt request low on low supply or wake timer expiry.
module rcd_decoder
    import rcd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        SCK,
    input  wire logic        SELECT_N,
    input  wire logic        SERIAL_IN,
    input  wire logic        STRENGTH_COMPARE_OUT,
    input  wire logic        QUALITY_DETECTOR_OUT,
    input  wire logic        CLOCK_LOCK,
    input  wire logic        LOW_SUPPLY_DETECTOR,
    input  wire logic        WAKE_TIMEOUT_EVENT,
    input  wire logic        SLEEP,
    input  wire logic        IRQ_CLEAR,
    output logic [1:0]       BAND_SEL,
    output logic [6:0]       SYNTH_C2,
    output logic [1:0]       SYNTH_C1,
    output logic [3:0]       CRYSTAL_LOAD,
    output logic [2:0]       BASEBAND_BW,
    output logic             BATTERY_DETECT_ENABLE,
    output logic             WAKE_TIMER_ENABLE,
    output logic             CRYSTAL_KEEP_ON,
    output logic             CLOCK_OUT_DISABLE,
    output logic             CRYSTAL_RUN,
    output logic             CLOCK_OUT_RUN,
    output logic [11:0]      FREQ_WORD,
    output logic             VALID_DATA_FLAG,
    output logic [1:0]       LNA_GAIN_SEL,
    output logic [2:0]       STRENGTH_THRESH,
    output logic signed [7:0] EFFECTIVE_THRESH_DBM,
    output logic             RECEIVER_ENABLE,
    output logic [4:0]       WAKE_EXP,
    output logic [7:0]       WAKE_MANT,
    output logic             DUTY_ENABLE,
    output logic [6:0]       DUTY_D,
    output logic [4:0]       BATT_THRESH,
    output logic [2:0]       CLOCK_DIV_SEL,
    output logic             INTERRUPT_REQUEST_N
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [15:0] shift;
        logic [3:0]  cnt;
        logic        sck_d;
        logic        lsd_d;
        logic        wke_d;
        logic        irq;
        logic [15:0] cfg;
        logic [15:0] freq;
        logic [15:0] rx;
        logic [15:0] wake;
        logic [15:0] duty;
        logic [15:0] batt;
        logic        valid;
    } rcd_state_t;

    rcd_state_t st_r;
    rcd_state_t st_nxt;

    logic [2:0]  pins_s;
    logic        sck_s;
    logic        sel_n_s;
    logic        din_s;
    logic [4:0]  ev_s;
    logic [15:0] word;
    logic        word_done;

    //------------------------------------------------------------
    // Synchronisers
    //------------------------------------------------------------
    rcd_sync #(.W(3)) u_pin_sync (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      ({SCK, SELECT_N, SERIAL_IN}),
        .q      (pins_s)
    );

    rcd_sync #(.W(5)) u_ev_sync (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      ({STRENGTH_COMPARE_OUT, QUALITY_DETECTOR_OUT, CLOCK_LOCK,
                  LOW_SUPPLY_DETECTOR, WAKE_TIMEOUT_EVENT}),
        .q      (ev_s)
    );

    assign sck_s   = pins_s[2];
    assign sel_n_s = pins_s[1];
    assign din_s   = pins_s[0];

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        word         = {st_r.shift[14:0], din_s};
        word_done    = 1'b0;
        st_nxt.sck_d = sck_s;
        st_nxt.lsd_d = ev_s[1];
        st_nxt.wke_d = ev_s[0];

        if (sel_n_s) begin
            st_nxt.cnt   = RCD_CNT_RST;
            st_nxt.shift = '0;
        end else if (sck_s && !st_r.sck_d) begin
            st_nxt.shift = word;
            st_nxt.cnt   = st_r.cnt + 4'h1;
            word_done    = (st_r.cnt == 4'hF);
        end

        if (word_done) begin
            if (word[15:13] == RCD_PFX_CFG) begin
                st_nxt.cfg = word;
            end else if (word[15:12] == RCD_PFX_FREQ) begin
                if (word[11:0] >= RCD_FREQ_MIN &&
                    word[11:0] <= RCD_FREQ_MAX) begin
                    st_nxt.freq = word;
                end
            end else if (word[15:13] == RCD_PFX_WAKE) begin
                st_nxt.wake = word;
            end else if (word[15:8] == RCD_PFX_RX) begin
                st_nxt.rx = word;
            end else if (word[15:8] == RCD_PFX_DUTY) begin
                st_nxt.duty = word;
            end else if (word[15:8] == RCD_PFX_BATT) begin
                st_nxt.batt = word;
            end
        end

        // Valid data indicator source
        case (st_r.rx[7:6])
            2'b00:   st_nxt.valid = ev_s[4];
            2'b01:   st_nxt.valid = ev_s[3];
            2'b10:   st_nxt.valid = ev_s[2];
            default: st_nxt.valid = 1'b1;
        endcase

        // Interrupt on low supply or timer expiry; set wins over clear
        if (IRQ_CLEAR) begin
            st_nxt.irq = 1'b0;
        end
        if ((st_r.cfg[RCD_CFG_BDE] && ev_s[1] && !st_r.lsd_d) ||
            (st_r.cfg[RCD_CFG_WTE] && ev_s[0] && !st_r.wke_d)) begin
            st_nxt.irq = 1'b1;
        end
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r       <= '0;
            st_r.sck_d <= 1'b1;
            // Match the synchroniser reset level: no false event edge
            st_r.lsd_d <= 1'b1;
            st_r.wke_d <= 1'b1;
            st_r.cfg   <= RCD_CFG_RST;
            st_r.freq  <= RCD_FREQ_RST;
            st_r.rx    <= RCD_RX_RST;
            st_r.wake  <= RCD_WAKE_RST;
            st_r.duty  <= RCD_DUTY_RST;
            st_r.batt  <= RCD_BATT_RST;
            st_r.valid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    //------------------------------------------------------------
    // Decoded fields
    //------------------------------------------------------------
    logic signed [7:0] gain_db;
    logic signed [7:0] thresh_db;

    always_comb begin
        case (st_r.rx[5:4])
            2'b00:   gain_db = 8'sh00;
            2'b01:   gain_db = -8'sd14;
            2'b10:   gain_db = -8'sd6;
            default: gain_db = -8'sd20;
        endcase
        thresh_db = 8'(-8'sd103 + $signed({2'b00, st_r.rx[3:1], 3'b000})
                    - $signed({4'b0000, st_r.rx[3:1], 1'b0}));
    end

    always_comb begin
        case (st_r.cfg[12:11])
            2'b00:   begin SYNTH_C1 = 2'd1; SYNTH_C2 = 7'd31; end
            2'b01:   begin SYNTH_C1 = 2'd1; SYNTH_C2 = 7'd43; end
            2'b10:   begin SYNTH_C1 = 2'd2; SYNTH_C2 = 7'd43; end
            default: begin SYNTH_C1 = 2'd3; SYNTH_C2 = 7'd30; end
        endcase
    end

    assign EFFECTIVE_THRESH_DBM  = thresh_db + gain_db;
    assign BAND_SEL              = st_r.cfg[12:11];
    assign CRYSTAL_LOAD          = st_r.cfg[7:4];
    assign BASEBAND_BW           = st_r.cfg[3:1];
    assign BATTERY_DETECT_ENABLE = st_r.cfg[RCD_CFG_BDE];
    assign WAKE_TIMER_ENABLE     = st_r.cfg[RCD_CFG_WTE];
    assign CRYSTAL_KEEP_ON       = st_r.cfg[RCD_CFG_XKO];
    assign CLOCK_OUT_DISABLE     = st_r.cfg[RCD_CFG_CKD];
    assign RECEIVER_ENABLE       = st_r.rx[0];
    assign CRYSTAL_RUN           = st_r.rx[0] ||
                                   (SLEEP && st_r.cfg[RCD_CFG_XKO]);
    assign CLOCK_OUT_RUN         = CRYSTAL_RUN &&
                                   !st_r.cfg[RCD_CFG_CKD];
    assign FREQ_WORD             = st_r.freq[11:0];
    assign VALID_DATA_FLAG       = st_r.valid;
    assign LNA_GAIN_SEL          = st_r.rx[5:4];
    assign STRENGTH_THRESH       = st_r.rx[3:1];
    assign WAKE_EXP              = st_r.wake[12:8];
    assign WAKE_MANT             = st_r.wake[7:0];
    assign DUTY_ENABLE           = st_r.duty[0];
    assign DUTY_D                = st_r.duty[7:1];
    assign BATT_THRESH           = st_r.batt[4:0];
    assign CLOCK_DIV_SEL         = st_r.batt[7:5];
    assign INTERRUPT_REQUEST_N   = !st_r.irq;

endmodule
`default_nettype wire

/* File: rtl/rcd_pkg.sv */
// Constants, field layout and defaults of the receiver command decoder.
// Assumes a single 50 MHz system clock domain.
package rcd_pkg;

    localparam int          RCD_WORD_W      = 16;
    localparam int          RCD_CLK_NS      = 20;
    // Default command words after reset
    localparam logic [15:0] RCD_CFG_RST     = 16'h893A;
    localparam logic [15:0] RCD_FREQ_RST    = 16'hA680;
    localparam logic [15:0] RCD_RX_RST      = 16'hC0C1;
    localparam logic [15:0] RCD_WAKE_RST    = 16'hE196;
    localparam logic [15:0] RCD_DUTY_RST    = 16'hCC0E;
    localparam logic [15:0] RCD_BATT_RST    = 16'hC200;
    // Command code prefixes
    localparam logic [2:0]  RCD_PFX_CFG     = 3'h4;
    localparam logic [3:0]  RCD_PFX_FREQ    = 4'hA;
    localparam logic [2:0]  RCD_PFX_WAKE    = 3'h7;
    localparam logic [7:0]  RCD_PFX_RX      = 8'hC0;
    localparam logic [7:0]  RCD_PFX_DUTY    = 8'hCC;
    localparam logic [7:0]  RCD_PFX_BATT    = 8'hC2;
    // Accepted frequency word range
    localparam logic [11:0] RCD_FREQ_MIN    = 12'h060;
    localparam logic [11:0] RCD_FREQ_MAX    = 12'hF3F;
    // Configuration field positions
    localparam int          RCD_CFG_BAND    = 11;
    localparam int          RCD_CFG_BDE     = 10;
    localparam int          RCD_CFG_WTE     = 9;
    localparam int          RCD_CFG_XKO     = 8;
    localparam int          RCD_CFG_XTAL    = 4;
    localparam int          RCD_CFG_BW      = 1;
    localparam int          RCD_CFG_CKD     = 0;
    // Bit counter reset value
    localparam logic [3:0]  RCD_CNT_RST     = 4'h0;

endpackage

/* File: rtl/rcd_sync.sv */
// Two-stage synchroniser for the serial pins and the event inputs.
// Assumes asynchronous inputs and the CLK domain of the decoder.
`timescale 1ns/1ps
`default_nettype none
module rcd_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: sim/rcd_decoder_bench.sv */
// Self-checking bench of the receiver command decoder.
// Assumes the host model on the serial pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module rcd_decoder_bench import rcd_pkg::*;;
    logic CLK, ARST_N, SCK, SELECT_N, SERIAL_IN, STRENGTH_COMPARE_OUT;
    logic QUALITY_DETECTOR_OUT, CLOCK_LOCK, LOW_SUPPLY_DETECTOR, SLEEP;
    logic WAKE_TIMEOUT_EVENT, IRQ_CLEAR, BATTERY_DETECT_ENABLE, DUTY_ENABLE;
    logic WAKE_TIMER_ENABLE, CRYSTAL_KEEP_ON, CLOCK_OUT_DISABLE, CRYSTAL_RUN;
    logic CLOCK_OUT_RUN, VALID_DATA_FLAG, RECEIVER_ENABLE, INTERRUPT_REQUEST_N;
    logic [1:0] BAND_SEL, SYNTH_C1, LNA_GAIN_SEL;
    logic [2:0] BASEBAND_BW, STRENGTH_THRESH, CLOCK_DIV_SEL;
    logic [3:0] CRYSTAL_LOAD;
    logic [4:0] WAKE_EXP, BATT_THRESH;
    logic [6:0] SYNTH_C2, DUTY_D;
    logic [7:0] WAKE_MANT;
    logic [11:0] FREQ_WORD;
    logic signed [7:0] EFFECTIVE_THRESH_DBM;
    logic [15:0] sh_cfg, sh_freq, sh_rx, sh_wake, sh_duty, sh_batt, w;
    logic [15:0] edge_w [6] = '{16'hA05F, 16'hA060, 16'hAF3F, 16'hAF40,
                                16'hA000, 16'hAFFF};
    int err_count = 0;
    int checks = 0;
    rcd_host i_host (.SCK, .SELECT_N, .SERIAL_IN);
    rcd_decoder i_dut (.CLK, .ARST_N, .SCK, .SELECT_N, .SERIAL_IN,
        .STRENGTH_COMPARE_OUT, .QUALITY_DETECTOR_OUT, .CLOCK_LOCK,
        .LOW_SUPPLY_DETECTOR, .WAKE_TIMEOUT_EVENT, .SLEEP, .IRQ_CLEAR,
        .BAND_SEL, .SYNTH_C2, .SYNTH_C1, .CRYSTAL_LOAD, .BASEBAND_BW,
        .BATTERY_DETECT_ENABLE, .WAKE_TIMER_ENABLE, .CRYSTAL_KEEP_ON,
        .CLOCK_OUT_DISABLE, .CRYSTAL_RUN, .CLOCK_OUT_RUN, .FREQ_WORD,
        .VALID_DATA_FLAG, .LNA_GAIN_SEL, .STRENGTH_THRESH, .WAKE_EXP,
        .EFFECTIVE_THRESH_DBM, .RECEIVER_ENABLE, .WAKE_MANT, .DUTY_D,
        .DUTY_ENABLE, .BATT_THRESH, .CLOCK_DIV_SEL, .INTERRUPT_REQUEST_N);
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] eff(input logic [15:0] r);
        int g;
        g = r[5:4] == 2'h0 ? 0 : r[5:4] == 2'h1 ? -14
            : r[5:4] == 2'h2 ? -6 : -20;
        return 16'(-103 + 6 * int'(r[3:1]) + g);
    endfunction
    task automatic check_all();
        logic x;
        logic v;
        x = sh_rx[0] | (SLEEP & sh_cfg[8]);
        v = sh_rx[7] ? sh_rx[6] | CLOCK_LOCK
            : sh_rx[6] ? QUALITY_DETECTOR_OUT : STRENGTH_COMPARE_OUT;
        cmp("config", sh_cfg[12:0], {BAND_SEL, BATTERY_DETECT_ENABLE,
            WAKE_TIMER_ENABLE, CRYSTAL_KEEP_ON, CRYSTAL_LOAD, BASEBAND_BW,
            CLOCK_OUT_DISABLE});
        cmp("freq", sh_freq[11:0], FREQ_WORD);
        cmp("rx", sh_rx[5:0], {LNA_GAIN_SEL, STRENGTH_THRESH,
            RECEIVER_ENABLE});
        cmp("thresh", eff(sh_rx), EFFECTIVE_THRESH_DBM);
        cmp("valid_data", v, VALID_DATA_FLAG);
        cmp("wake", sh_wake[12:0], {WAKE_EXP, WAKE_MANT});
        cmp("duty", sh_duty[7:0], {DUTY_D, DUTY_ENABLE});
        cmp("batt", sh_batt[7:0],
            {CLOCK_DIV_SEL, BATT_THRESH});
        cmp("run", {x, x & ~sh_cfg[0]}, {CRYSTAL_RUN, CLOCK_OUT_RUN});
    endtask
    task automatic put(input logic [15:0] w, input int n);
        @(posedge CLK);
        #2;
        {SLEEP, STRENGTH_COMPARE_OUT, QUALITY_DETECTOR_OUT, CLOCK_LOCK} =
            4'($urandom);
        i_host.send(w, n);
        if (n == 16) begin
            if (w[15:13] == 3'h4) sh_cfg = w;
            if (w[15:12] == 4'hA && w[11:0] >= 12'h060 && w[11:0] <= 12'hF3F)
                sh_freq = w;
            if (w[15:13] == 3'h7) sh_wake = w;
            if (w[15:8] == 8'hC0) sh_rx = w;
            if (w[15:8] == 8'hCC) sh_duty = w;
            if (w[15:8] == 8'hC2) sh_batt = w;
        end
        repeat (2) @(posedge CLK);
        #2 check_all();
    endtask
    task automatic irq_step(input logic lo, input logic wk, input logic e);
        LOW_SUPPLY_DETECTOR = lo;
        WAKE_TIMEOUT_EVENT = wk;
        repeat (8) @(posedge CLK);
        #2 cmp("irq_n", 16'(e), 16'(INTERRUPT_REQUEST_N));
        {LOW_SUPPLY_DETECTOR, WAKE_TIMEOUT_EVENT, IRQ_CLEAR} = 3'h1;
        repeat (6) @(posedge CLK);
        #2 IRQ_CLEAR = 1'b0;
        cmp("irq_n", 16'h1, 16'(INTERRUPT_REQUEST_N));
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        #1_000_000;
        err_count++;
        complete_run();
    end
    initial begin
        {ARST_N, SLEEP, STRENGTH_COMPARE_OUT, QUALITY_DETECTOR_OUT} = 4'h0;
        {CLOCK_LOCK, LOW_SUPPLY_DETECTOR, WAKE_TIMEOUT_EVENT, IRQ_CLEAR} = 4'h0;
        void'($urandom(32'h67bb_e7fe));
        {sh_cfg, sh_freq, sh_rx} = {RCD_CFG_RST, RCD_FREQ_RST, RCD_RX_RST};
        {sh_wake, sh_duty} = {RCD_WAKE_RST, RCD_DUTY_RST};
        sh_batt = RCD_BATT_RST;
        repeat (8) @(posedge CLK);
        #2 ARST_N = 1'b1;
        repeat (4) @(posedge CLK);
        #2 check_all();
        $display("test reset done");
        foreach (edge_w[i]) put(edge_w[i], 16);
        put(16'hA123, 8);
        put(16'hA123, 16);
        for (int i = 0; i < 8; i++)
            put({8'hC2, 3'(i), 5'(31 - i)}, 16);
        for (int i = 0; i < 4; i++)
            put({8'hC0, 2'(i), 6'(i * 9)}, 16);
        $display("test corners done");
        repeat (40) begin
            w = 16'($urandom);
            case ($urandom_range(6))
                0: w[15:13] = 3'h4;
                1: w[15:12] = 4'hA;
                2: w[15:13] = 3'h7;
                3: w[15:8] = 8'hC0;
                4: w[15:8] = 8'hCC;
                5: w[15:8] = 8'hC2;
                default: w[15:8] = 8'hC6;
            endcase
            put(w, 16);
        end
        $display("test random done");
        put(16'h8C3A, 16);
        irq_step(1'b1, 1'b0, 1'b0);
        put(16'h8A3A, 16);
        irq_step(1'b1, 1'b0, 1'b1);
        irq_step(1'b0, 1'b1, 1'b0);
        $display("test interrupt done");
        complete_run();
    end
endmodule
bind rcd_decoder rcd_decoder_props i_props (.CLK, .ARST_N, .SELECT_N,
    .LOW_SUPPLY_DETECTOR, .SLEEP, .BAND_SEL, .SYNTH_C1, .SYNTH_C2,
    .BATTERY_DETECT_ENABLE, .WAKE_TIMER_ENABLE, .CRYSTAL_KEEP_ON,
    .CLOCK_OUT_DISABLE, .CRYSTAL_RUN, .CLOCK_OUT_RUN, .FREQ_WORD,
    .LNA_GAIN_SEL, .STRENGTH_THRESH, .EFFECTIVE_THRESH_DBM,
    .RECEIVER_ENABLE, .INTERRUPT_REQUEST_N);
`default_nettype wire

/* File: sim/rcd_decoder_props.sv */
// Checker of the receiver command decoder, bound to its top ports.
// Assumes one CLK domain and frames from the host model.
`timescale 1ns/1ps
`default_nettype none
module rcd_decoder_props (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        SELECT_N,
    input wire logic        LOW_SUPPLY_DETECTOR,
    input wire logic        SLEEP,
    input wire logic [1:0]  BAND_SEL,
    input wire logic [1:0]  SYNTH_C1,
    input wire logic [6:0]  SYNTH_C2,
    input wire logic        BATTERY_DETECT_ENABLE,
    input wire logic        WAKE_TIMER_ENABLE,
    input wire logic        CRYSTAL_KEEP_ON,
    input wire logic        CLOCK_OUT_DISABLE,
    input wire logic        CRYSTAL_RUN,
    input wire logic        CLOCK_OUT_RUN,
    input wire logic [11:0] FREQ_WORD,
    input wire logic [1:0]  LNA_GAIN_SEL,
    input wire logic [2:0]  STRENGTH_THRESH,
    input wire logic signed [7:0] EFFECTIVE_THRESH_DBM,
    input wire logic        RECEIVER_ENABLE,
    input wire logic        INTERRUPT_REQUEST_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    // Cycles since select went high, saturating
    always_comb idle_nxt = SELECT_N ? idle_r + {3'h0, idle_r != 4'hF} : 4'h0;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) idle_r <= 4'h0;
        else idle_r <= idle_nxt;
    end
    function automatic logic [8:0] band_k(input logic [1:0] b);
        case (b)
            2'h0: return {2'h1, 7'h1F};
            2'h1: return {2'h1, 7'h2B};
            2'h2: return {2'h2, 7'h2B};
            default: return {2'h3, 7'h1E};
        endcase
    endfunction
    function automatic int gain_db(input logic [1:0] g);
        return g == 2'h0 ? 0 : g == 2'h1 ? -14 : g == 2'h2 ? -6 : -20;
    endfunction
    a_crystal_run: assert property (
        CRYSTAL_RUN == (RECEIVER_ENABLE | (SLEEP & CRYSTAL_KEEP_ON)))
        else $error("crystal run mismatch");
    a_clock_out: assert property (
        CLOCK_OUT_RUN == (CRYSTAL_RUN & !CLOCK_OUT_DISABLE))
        else $error("clock output mismatch");
    a_synth_band: assert property (
        {SYNTH_C1, SYNTH_C2} == band_k(BAND_SEL))
        else $error("band constants mismatch");
    a_eff_thresh: assert property (
        int'(EFFECTIVE_THRESH_DBM) == -103 + 6 * int'(STRENGTH_THRESH)
        + gain_db(LNA_GAIN_SEL)) else $error("threshold mismatch");
    a_freq_range: assert property (
        FREQ_WORD >= 12'h060 && FREQ_WORD <= 12'hF3F)
        else $error("frequency word out of range");
    a_reg_frame: assert property (
        $changed({FREQ_WORD, BAND_SEL, LNA_GAIN_SEL, RECEIVER_ENABLE})
        |-> idle_r < 4'h8) else $error("register changed outside frame");
    a_irq_enable: assert property (
        $fell(INTERRUPT_REQUEST_N) |-> BATTERY_DETECT_ENABLE
        | WAKE_TIMER_ENABLE) else $error("interrupt while disabled");
    a_irq_set: assert property (
        $rose(LOW_SUPPLY_DETECTOR) && BATTERY_DETECT_ENABLE
        |-> ##[1:6] !INTERRUPT_REQUEST_N) else $error("interrupt missing");
    c_irq: cover property ($fell(INTERRUPT_REQUEST_N));
    c_freq: cover property ($changed(FREQ_WORD));
    c_keep: cover property (SLEEP && CRYSTAL_KEEP_ON && !RECEIVER_ENABLE);
endmodule
`default_nettype wire

/* File: sim/rcd_host.sv */
// Host side model driving command frames on the serial pins.
// Assumes the bench calls send just after a CLK edge.
`timescale 1ns/1ps
`default_nettype none
module rcd_host (
    output var logic SCK,
    output var logic SELECT_N,
    output var logic SERIAL_IN
);
    initial begin
        SCK = 1'b0;
        SELECT_N = 1'b1;
        SERIAL_IN = 1'b0;
    end
    // Sends the top n bits of w; the clock stands low outside frames
    task automatic send(input logic [15:0] w, input int n);
        SELECT_N = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            SERIAL_IN = w[i];
            #80 SCK = 1'b1;
            #80 SCK = 1'b0;
        end
        #20 SELECT_N = 1'b1;
        SERIAL_IN = ~SERIAL_IN;
        #100;
    endtask
endmodule
`default_nettype wire
